// ---- logic/udcc_params.svh ----
/*
  Constants for the up/down counter compare and capture block: register
  addresses, address width, reset values, edge-select codes and clear-source codes.
  Assumes it is included by bare name from the package and the modules.

// Summary of operation
// - match_value_0 always compared; timer mode or submode A pulse every match.
// - submode B: match0 pulse only while counting down.
// - match_value_1 always compared; timer mode or submode A pulse every match.
// - submode B: match1 pulse only while counting down.
// - match registers have word access plus a low-byte alias.
// - reset clears all four value registers to zero.
// - function-select 0 makes a channel capture, 1 makes it compare.
// - capture triggers are ignored while count enable is 0.
// - valid capture edge latches counter; value held until next capture.
// - valid edge is rising, falling or both, per edge-select field.
// - in capture mode a valid edge raises the channel interrupt.
// - in compare mode equality with counter raises the channel interrupt.
// - channel 0 capture unavailable while up/down mode uses its pin.
// - channel 1 capture unavailable when submode A uses external clear.
// - channel registers have word access plus a low-byte alias.
// - counter mode bit 0 is up-count timer, 1 is up/down counting.
// - count enable 1 allows counting, 0 stops it.
// - submode B clears counter on match0 counting up, match1 counting down.
*/
`ifndef UDCC_PARAMS_SVH
`define UDCC_PARAMS_SVH

`define UDCC_ADDR_W         16
`define UDCC_ADDR_MATCH0    16'hFF12
`define UDCC_ADDR_MATCH1    16'hFF14
`define UDCC_ADDR_CC0       16'hFF16
`define UDCC_ADDR_CC1       16'hFF18
`define UDCC_VALUE_RESET    16'h0000
`define UDCC_ZERO16         16'h0000
`define UDCC_ZERO8          8'h00
`define UDCC_EDGE_NONE      2'h0
`define UDCC_EDGE_RISE      2'h1
`define UDCC_EDGE_FALL      2'h2
`define UDCC_EDGE_BOTH      2'h3
`define UDCC_CLR_EXT_ONLY   2'h0
`define UDCC_CLR_EXT_MATCH  2'h2

`endif

// ---- logic/udcc_pkg.sv ----
/*
  Types shared by the compare/capture block.
  Assumes udcc_params.svh is on the include path.
*/
package udcc_pkg;
  `include "udcc_params.svh"

  typedef logic [15:0] udcc_word_t;

  // counter state seen by this block
  typedef struct packed {
    udcc_word_t count;
    logic       count_down;
    logic       counter_mode_bit;
    logic       updown_submode_bit;
    logic       count_enable_bit;
    logic [1:0] clear_source;
  } udcc_counter_s;

  typedef struct packed {
    logic match0_irq;
    logic match1_irq;
    logic channel0_compare_irq;
    logic channel1_compare_irq;
  } udcc_irq_s;

  typedef enum logic [1:0] {
    UDCC_TIMER,
    UDCC_SUBMODE_A,
    UDCC_SUBMODE_B
  } udcc_mode_e;
endpackage : udcc_pkg

// ---- logic/udcc_edge_detect.sv ----
/*
  Synchronises one capture pin and reports the selected edge as a pulse.
  Assumes the pin is asynchronous to clk_i.
*/
`timescale 1ns/1ps
`include "udcc_params.svh"
module udcc_edge_detect
  import udcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       pin_i,
  input  wire logic [1:0] edge_sel_i,
  output logic            edge_o
);
  logic sync_a;
  logic sync_b;
  logic prev;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev   <= 1'b0;
    end else begin
      sync_a <= pin_i;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  always_comb begin
    case (edge_sel_i)
      `UDCC_EDGE_RISE: edge_o = sync_b & ~prev;
      `UDCC_EDGE_FALL: edge_o = ~sync_b & prev;
      `UDCC_EDGE_BOTH: edge_o = sync_b ^ prev;
      default:         edge_o = 1'b0;
    endcase
  end
endmodule : udcc_edge_detect

// ---- logic/udcc_value_reg.sv ----
/*
  One 16-bit value register with word write, low-byte write and load.
  Assumes write strobes are one-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
`include "udcc_params.svh"
module udcc_value_reg
  import udcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       wr_word_i,
  input  wire logic       wr_low_i,
  input  wire logic       load_i,
  input  wire udcc_word_t wdata_i,
  input  wire udcc_word_t load_data_i,
  output udcc_word_t      value_o
);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      value_o <= `UDCC_VALUE_RESET;
    end else if (load_i) begin
      value_o <= load_data_i;
    end else if (wr_word_i) begin
      value_o <= wdata_i;
    end else if (wr_low_i) begin
      value_o <= {value_o[15:8], wdata_i[7:0]};
    end
  end
endmodule : udcc_value_reg

// ---- logic/udcc_compare_capture.sv ----
/*
  Compare and capture/compare channels of a 16-bit up/down counter.
  Assumes the counter, clear logic and control registers live outside and
  present their state on cnt_i; CPU access is a simple strobed port.
*/
`timescale 1ns/1ps
`include "udcc_params.svh"
module udcc_compare_capture
  import udcc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       byte_i,
  input  wire udcc_word_t wdata_i,
  output udcc_word_t      rdata_o,
  input  wire udcc_counter_s cnt_i,
  input  wire logic       channel0_function_select_i,
  input  wire logic       channel1_function_select_i,
  input  wire logic [1:0] edge_sel0_i,
  input  wire logic [1:0] edge_sel1_i,
  input  wire logic       capture_in_0_i,
  input  wire logic       capture_in_1_i,
  output udcc_irq_s       irq_o,
  output logic            clear_up_match_o,
  output logic            clear_down_match_o
);
  udcc_word_t match0;
  udcc_word_t match1;
  udcc_word_t cc0;
  udcc_word_t cc1;
  udcc_mode_e mode;
  logic       edge0;
  logic       edge1;
  logic       cap0_ok;
  logic       cap1_ok;
  logic       cap0;
  logic       cap1;
  logic       sel_m0;
  logic       sel_m1;
  logic       sel_c0;
  logic       sel_c1;
  logic       eq_m0;
  logic       eq_m1;
  logic       eq_c0;
  logic       eq_c1;
  logic       prev_eq_m0;
  logic       prev_eq_m1;
  logic       prev_eq_c0;
  logic       prev_eq_c1;
  udcc_irq_s  next_irq;

  // mode decode from the counter control bits
  always_comb begin
    if (!cnt_i.counter_mode_bit) begin
      mode = UDCC_TIMER;
    end else if (cnt_i.updown_submode_bit) begin
      mode = UDCC_SUBMODE_B;
    end else begin
      mode = UDCC_SUBMODE_A;
    end
  end

  assign sel_m0 = (addr_i == `UDCC_ADDR_MATCH0);
  assign sel_m1 = (addr_i == `UDCC_ADDR_MATCH1);
  assign sel_c0 = (addr_i == `UDCC_ADDR_CC0);
  assign sel_c1 = (addr_i == `UDCC_ADDR_CC1);

  udcc_edge_detect u_edge0 (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .pin_i      (capture_in_0_i),
    .edge_sel_i (edge_sel0_i),
    .edge_o     (edge0)
  );

  udcc_edge_detect u_edge1 (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .pin_i      (capture_in_1_i),
    .edge_sel_i (edge_sel1_i),
    .edge_o     (edge1)
  );

  // pin sharing: direction pin in up/down mode, clear pin in submode A
  assign cap0_ok = !cnt_i.counter_mode_bit;
  assign cap1_ok = !((mode == UDCC_SUBMODE_A) &&
                     ((cnt_i.clear_source == `UDCC_CLR_EXT_ONLY) ||
                      (cnt_i.clear_source == `UDCC_CLR_EXT_MATCH)));
  assign cap0 = edge0 && cap0_ok && cnt_i.count_enable_bit &&
                !channel0_function_select_i;
  assign cap1 = edge1 && cap1_ok && cnt_i.count_enable_bit &&
                !channel1_function_select_i;

  udcc_value_reg u_match0 (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .wr_word_i   (wr_i && sel_m0 && !byte_i),
    .wr_low_i    (wr_i && sel_m0 && byte_i),
    .load_i      (1'b0),
    .wdata_i     (wdata_i),
    .load_data_i (`UDCC_ZERO16),
    .value_o     (match0)
  );

  udcc_value_reg u_match1 (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .wr_word_i   (wr_i && sel_m1 && !byte_i),
    .wr_low_i    (wr_i && sel_m1 && byte_i),
    .load_i      (1'b0),
    .wdata_i     (wdata_i),
    .load_data_i (`UDCC_ZERO16),
    .value_o     (match1)
  );

  // capture wins over a prohibited CPU write in the same cycle
  udcc_value_reg u_cc0 (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .wr_word_i   (wr_i && sel_c0 && !byte_i),
    .wr_low_i    (wr_i && sel_c0 && byte_i),
    .load_i      (cap0),
    .wdata_i     (wdata_i),
    .load_data_i (cnt_i.count),
    .value_o     (cc0)
  );

  udcc_value_reg u_cc1 (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .wr_word_i   (wr_i && sel_c1 && !byte_i),
    .wr_low_i    (wr_i && sel_c1 && byte_i),
    .load_i      (cap1),
    .wdata_i     (wdata_i),
    .load_data_i (cnt_i.count),
    .value_o     (cc1)
  );

  // read data, registered one cycle after rd_i
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= `UDCC_ZERO16;
    end else if (rd_i) begin
      if (sel_m0) begin
        rdata_o <= byte_i ? {`UDCC_ZERO8, match0[7:0]} : match0;
      end else if (sel_m1) begin
        rdata_o <= byte_i ? {`UDCC_ZERO8, match1[7:0]} : match1;
      end else if (sel_c0) begin
        rdata_o <= byte_i ? {`UDCC_ZERO8, cc0[7:0]} : cc0;
      end else if (sel_c1) begin
        rdata_o <= byte_i ? {`UDCC_ZERO8, cc1[7:0]} : cc1;
      end else begin
        rdata_o <= `UDCC_ZERO16;
      end
    end
  end

  assign eq_m0 = (cnt_i.count == match0);
  assign eq_m1 = (cnt_i.count == match1);
  assign eq_c0 = (cnt_i.count == cc0) && channel0_function_select_i;
  assign eq_c1 = (cnt_i.count == cc1) && channel1_function_select_i;

  // previous-cycle equality so a held match gives one pulse
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // counter and match values both reset to zero: no entry at release
      prev_eq_m0 <= 1'b1;
      prev_eq_m1 <= 1'b1;
      prev_eq_c0 <= 1'b0;
      prev_eq_c1 <= 1'b0;
    end else begin
      prev_eq_m0 <= eq_m0;
      prev_eq_m1 <= eq_m1;
      prev_eq_c0 <= eq_c0;
      prev_eq_c1 <= eq_c1;
    end
  end

  always_comb begin
    next_irq = '0;
    case (mode)
      UDCC_SUBMODE_B: begin
        next_irq.match0_irq = eq_m0 && !prev_eq_m0 && cnt_i.count_down;
        next_irq.match1_irq = eq_m1 && !prev_eq_m1 && cnt_i.count_down;
      end
      default: begin
        next_irq.match0_irq = eq_m0 && !prev_eq_m0;
        next_irq.match1_irq = eq_m1 && !prev_eq_m1;
      end
    endcase
    next_irq.channel0_compare_irq = cap0 || (eq_c0 && !prev_eq_c0);
    next_irq.channel1_compare_irq = cap1 || (eq_c1 && !prev_eq_c1);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= '0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // clear requests to the counter in submode B, only while counting
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clear_up_match_o   <= 1'b0;
      clear_down_match_o <= 1'b0;
    end else begin
      clear_up_match_o   <= (mode == UDCC_SUBMODE_B) && eq_m0 &&
                            !cnt_i.count_down && cnt_i.count_enable_bit;
      clear_down_match_o <= (mode == UDCC_SUBMODE_B) && eq_m1 &&
                            cnt_i.count_down && cnt_i.count_enable_bit;
    end
  end
endmodule : udcc_compare_capture

// ---- sim/udcc_cnt_model.sv ----
/*
  Counter model that feeds cnt_i of the compare block.
  Assumes step_i pulses pace the count and clr_i comes from the block.
*/
`timescale 1ns/1ps
module udcc_cnt_model
  import udcc_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          step_i,
  input  wire logic          clr_i,
  input  wire udcc_counter_s ctl_i,
  output udcc_counter_s      cnt_o
);
  udcc_word_t cnt;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt <= 16'h0000;
    else if (clr_i) cnt <= 16'h0000;
    else if (step_i && ctl_i.count_enable_bit) begin
      if (ctl_i.counter_mode_bit && ctl_i.count_down) cnt <= cnt - 16'h0001;
      else cnt <= cnt + 16'h0001;
    end
  end
  assign cnt_o = {cnt, ctl_i[5:0]};
endmodule : udcc_cnt_model

// ---- sim/udcc_compare_capture_sva.sv ----
/*
  Port checker for the compare/capture block, bound to its top.
  Assumes match registers change only through wr_i.
*/
`timescale 1ns/1ps
module udcc_compare_capture_sva
  import udcc_pkg::*;
(
  input wire logic          clk_i,
  input wire logic          reset_n_i,
  input wire logic [15:0]   addr_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic          byte_i,
  input wire udcc_word_t    wdata_i,
  input wire udcc_word_t    rdata_o,
  input wire udcc_counter_s cnt_i,
  input wire logic          channel0_function_select_i,
  input wire logic          channel1_function_select_i,
  input wire udcc_irq_s     irq_o,
  input wire logic          clear_up_match_o,
  input wire logic          clear_down_match_o
);
  udcc_word_t m0, m1;
  logic [7:0] m1l;
  logic       e0, e1, mb, cu, cd;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      m0 <= 16'h0000;
      m1 <= 16'h0000;
    end else if (wr_i && addr_i == 16'hFF12) begin
      m0 <= byte_i ? {m0[15:8], wdata_i[7:0]} : wdata_i;
    end else if (wr_i && addr_i == 16'hFF14) begin
      m1 <= byte_i ? {m1[15:8], wdata_i[7:0]} : wdata_i;
    end
  end
  assign m1l = m1[7:0];
  assign e0  = cnt_i.count == m0;
  assign e1  = cnt_i.count == m1;
  assign mb  = cnt_i.counter_mode_bit && cnt_i.updown_submode_bit;
  assign cu  = mb && !cnt_i.count_down && e0 && cnt_i.count_enable_bit;
  assign cd  = mb && cnt_i.count_down && e1 && cnt_i.count_enable_bit;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  match0_fire_a: assert property (e0 && !$past(e0) &&
    (!mb || cnt_i.count_down) |=> irq_o.match0_irq) else $error("m0 irq");
  match1_fire_a: assert property (e1 && !$past(e1) &&
    (!mb || cnt_i.count_down) |=> irq_o.match1_irq) else $error("m1 irq");
  pulse_width_a: assert property (
    (irq_o & $past(irq_o)) == 4'h0) else $error("irq width");
  match0_read_a: assert property (rd_i && !byte_i && addr_i == 16'hFF12
    |=> rdata_o == $past(m0)) else $error("m0 read");
  alias_read_a: assert property (rd_i && byte_i && addr_i == 16'hFF14
    |=> rdata_o == {8'h00, $past(m1l)}) else $error("m1 low read");
  capture_off_a: assert property (
    (!cnt_i.count_enable_bit && !channel0_function_select_i)[*6]
    |=> !irq_o.channel0_compare_irq) else $error("cap with ce 0");
  shared_pin0_a: assert property (
    (cnt_i.counter_mode_bit && !channel0_function_select_i)[*6]
    |=> !irq_o.channel0_compare_irq) else $error("cap0 in updown");
  shared_pin1_a: assert property ((cnt_i.counter_mode_bit &&
    !cnt_i.updown_submode_bit && !cnt_i.clear_source[0] &&
    !channel1_function_select_i)[*6] |=> !irq_o.channel1_compare_irq)
    else $error("cap1 in mode a");
  clear_up_a: assert property (cu |=> clear_up_match_o)
    else $error("clear up");
  clear_down_a: assert property (clear_down_match_o |-> $past(cd))
    else $error("clear down");
endmodule : udcc_compare_capture_sva

bind udcc_compare_capture udcc_compare_capture_sva chk_u (
  .clk_i, .reset_n_i, .addr_i, .wr_i, .rd_i, .byte_i, .wdata_i, .rdata_o,
  .cnt_i, .channel0_function_select_i, .channel1_function_select_i, .irq_o,
  .clear_up_match_o, .clear_down_match_o
);

// ---- sim/tb.sv ----
/*
  Self-checking bench for the compare/capture block.
  Assumes the counter model on its far side and a 250 MHz clock.
*/
`timescale 1ns/1ps
module tb
  import udcc_pkg::*;
;
  logic          clk_i = 1'b0, reset_n_i = 1'b0, step = 1'b0;
  logic          wr_i = 1'b0, rd_i = 1'b0, byte_i = 1'b0, rd_d = 1'b0;
  logic          fs0 = 1'b0, fs1 = 1'b0, cap0 = 1'b0, cap1 = 1'b0;
  logic          mon = 1'b0, clr_up, clr_dn;
  logic [15:0]   addr_i = 16'h0000;
  logic [1:0]    es0 = 2'h0, es1 = 2'h0;
  udcc_word_t    wdata_i = 16'h0000, rdata_o, cnt = 16'h0000, v, w;
  udcc_counter_s ctl = '0, cnt_s;
  udcc_irq_s     irq_o;
  logic [3:0]    irq_q[$];
  udcc_word_t    rd_q[$];
  int            fails = 0, total_checks = 0, seed = 4, k;
  always #2 clk_i = ~clk_i;
  udcc_cnt_model cm_u (.clk_i, .reset_n_i, .step_i(step),
    .clr_i(clr_up | clr_dn), .ctl_i(ctl), .cnt_o(cnt_s));
  udcc_compare_capture dut_u (.clk_i, .reset_n_i, .addr_i, .wr_i, .rd_i,
    .byte_i, .wdata_i, .rdata_o, .cnt_i(cnt_s),
    .channel0_function_select_i(fs0), .channel1_function_select_i(fs1),
    .edge_sel0_i(es0), .edge_sel1_i(es1), .capture_in_0_i(cap0),
    .capture_in_1_i(cap1), .irq_o, .clear_up_match_o(clr_up),
    .clear_down_match_o(clr_dn));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic cmp_rd(input udcc_word_t e, input udcc_word_t g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH rdata exp %h got %h", e, g);
    end
  endtask : cmp_rd
  task automatic cmp_irq(input logic [3:0] e, input logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH irq exp %h got %h", e, g);
    end
  endtask : cmp_irq
  always @(posedge clk_i) begin
    if (rd_d) cmp_rd(rd_q.pop_front(), rdata_o);
    if (mon && irq_o !== 4'h0)
      cmp_irq(irq_q.size() ? irq_q.pop_front() : 4'h0, irq_o);
    rd_d <= rd_i;
  end
  task automatic bus(input logic r, input logic [15:0] a, input logic b,
                     input udcc_word_t d);
    @(posedge clk_i);
    #1;
    {addr_i, byte_i, wdata_i} = {a, b, d};
    if (r) rd_q.push_back(d);
    {rd_i, wr_i} = {r, !r};
    @(posedge clk_i);
    #1;
    {rd_i, wr_i} = 2'b00;
  endtask : bus
  task automatic stp;
    @(posedge clk_i);
    #1;
    step = 1'b1;
    cnt = (ctl.counter_mode_bit && ctl.count_down) ? cnt - 16'h0001
                                                   : cnt + 16'h0001;
    @(posedge clk_i);
    #1;
    step = 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : stp
  task automatic pin(input logic c, input logic p);
    if (c) cap1 = p;
    else cap0 = p;
    repeat (8) @(posedge clk_i);
    #1;
  endtask : pin
  task automatic drain;
    int i;
    for (i = 0; i < 60 && irq_q.size() > 0; i++) @(posedge clk_i);
    if (irq_q.size() > 0) begin
      fails++;
      $display("MISMATCH irq_wait exp 0 got %0d", irq_q.size());
      complete_run;
    end
    repeat (8) @(posedge clk_i);
    #1;
  endtask : drain
  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    reset_n_i = 1'b1;
    for (k = 0; k < 5; k++)
      bus(1'b1, 16'hFF12 + 16'(2 * k), 1'b0, 16'h0000);
    v = 16'($random(seed));
    w = 16'($random(seed));
    bus(1'b0, 16'hFF12, 1'b0, v);
    bus(1'b0, 16'hFF12, 1'b1, w);
    bus(1'b0, 16'hFF14, 1'b1, w);
    fs1 = 1'b1;
    bus(1'b0, 16'hFF18, 1'b0, v);
    bus(1'b0, 16'hFF18, 1'b1, w);
    bus(1'b1, 16'hFF12, 1'b0, {v[15:8], w[7:0]});
    bus(1'b1, 16'hFF14, 1'b1, {8'h00, w[7:0]});
    bus(1'b1, 16'hFF18, 1'b0, {v[15:8], w[7:0]});
    bus(1'b1, 16'hFF18 - 16'h0006, 1'b1, {8'h00, w[7:0]});
    bus(1'b1, 16'hFF18, 1'b1, {8'h00, w[7:0]});
    bus(1'b0, 16'hFF12, 1'b0, 16'h0003);
    bus(1'b0, 16'hFF14, 1'b0, 16'h0004);
    bus(1'b0, 16'hFF18, 1'b0, 16'h0002);
    mon = 1'b1;
    ctl.count_enable_bit = 1'b1;
    irq_q = '{4'h1, 4'h8, 4'h4};
    repeat (5) stp;
    drain;
    for (k = 0; k < 4; k++) begin
      es0 = k[1:0];
      if (k[0]) irq_q.push_back(4'h2);
      pin(1'b0, 1'b1);
      stp;
      if (k[1]) irq_q.push_back(4'h2);
      pin(1'b0, 1'b0);
      drain;
    end
    v = cnt;
    stp;
    ctl.count_enable_bit = 1'b0;
    pin(1'b0, 1'b1);
    pin(1'b0, 1'b0);
    drain;
    bus(1'b1, 16'hFF16, 1'b0, v);
    {ctl.counter_mode_bit, fs1, es1} = {2'b10, 2'h3};
    ctl.count_enable_bit = 1'b1;
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
    {ctl.clear_source, ctl.count_enable_bit} = 3'b010;
    pin(1'b0, 1'b0);
    ctl.count_enable_bit = 1'b1;
    irq_q.push_back(4'h1);
    pin(1'b1, 1'b1);
    ctl.count_enable_bit = 1'b0;
    bus(1'b1, 16'hFF18, 1'b0, cnt);
    bus(1'b0, 16'hFF12, 1'b0, cnt + 16'h0002);
    bus(1'b0, 16'hFF14, 1'b0, 16'hFFFF);
    {ctl.updown_submode_bit, ctl.count_enable_bit} = 2'b11;
    repeat (2) stp;
    cnt = 16'h0000;
    ctl.count_down = 1'b1;
    irq_q.push_back(4'h4);
    stp;
    drain;
    complete_run;
  end
endmodule : tb
